// >>> src/pdiv_top.sv
// Summary of operation
// RL1 - The divider stops whenever the PLL is off and runs only while it is on.
// RL2 - Direct division uses only the 12-bit counter, loaded from divisor bits 15 to 4.
// RL3 - Pulse swallow chains a 15/16 prescaler, a 4-bit swallow counter and the 12-bit counter.
// RL4 - One select bit picks the method: 0 is direct division, 1 is pulse swallow.
// RL5 - Software keeps the divisor in 10h..fffh for direct and 210h..ffffh for swallow.
// RL6 - All sixteen staged divisor bits take effect together when the top nibble is written.
// RL7 - Software writes the top divisor nibble last, even for a partial change.
// RL8 - Mode and divisor fields are reached through the block's own port registers.
// RL9 - Two 2-bit fields set the oscillator input gain and the IF input gain.
// RL10 - All gain bits reset to one and software keeps the nibble at fh.
// RL11 - Software always writes zero to the top bit of the mode nibble.
// RL12 - The divided pulse feeds phase comparator and IF counter; raw input feeds the doubler.
// RL13 - Divisor and mode registers keep their contents while the core supply is off.
// RL14 - Writing the reference select field also transfers the staged divisor.
// RL15 - Reference select all ones, its reset value, is the PLL-off mode.
// RL16 - The overall division ratio equals the programmed binary divisor in either mode.
// RL17 - Divisor and mode reset to zero and no pulses appear until the PLL is on.
module pdiv_top (
	input  wire logic        clk_sys,         // System clock, 40 MHz.
	input  wire logic        rst_b,           // Asynchronous reset, active low.
	input  wire logic        hsel,            // Slave select.
	input  wire logic [31:0] haddr,           // Byte address.
	input  wire logic [1:0]  htrans,          // Transfer type.
	input  wire logic        hwrite,          // Write when high.
	input  wire logic [2:0]  hsize,           // Transfer size, word only.
	input  wire logic [31:0] hwdata,          // Write data.
	input  wire logic        hready,          // Bus ready.
	output wire logic        hreadyout,       // Slave ready.
	output wire logic [31:0] hrdata,          // Read data.
	output wire logic        hresp,           // Always OKAY.
	input  wire logic        local_osc_input, // Oscillator input, synchronous.
	output wire logic        div_to_phase,    // Divided pulse to phase comparator.
	output wire logic        div_to_ifc,      // Divided pulse to IF counter.
	output wire logic        doubler_clk,     // Raw oscillator to voltage doubler.
	output wire logic [1:0]  osc_gain,        // Oscillator amplifier gain.
	output wire logic [1:0]  intfreq_gain,    // IF amplifier gain.
	output wire logic        pll_on,          // PLL running.
	output wire logic        core_supply_en   // Divider core supply request.
);
	logic        hreadyout_r;
	logic [31:0] hrdata_r;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [7:0]  addr_r;
	logic [3:0]  mode_r;
	logic [11:0] stage_lo_r;
	logic [3:0]  stage_hi_r;
	logic [15:0] active_div_r;
	logic [3:0]  gain_r;
	logic [3:0]  refsel_r;
	logic        osc_d_r;
	logic        div_phase_r;
	logic        div_ifc_r;
	logic        doubler_r;
	logic [1:0]  osc_gain_r;
	logic [1:0]  if_gain_r;
	logic        pll_on_r;
	logic        supply_r;
	logic        acc_ok;
	logic        wr_hi;
	logic        wr_ref;
	logic        run_now;
	logic [31:0] rd_mux;

	pdiv_core_if cif ();

	pdiv_core #(
		.MAIN_W (pdiv_pkg::DIV_LO_W),
		.SWAL_W (4)
	) u_core (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.cif     (cif.core)
	);

	assign hreadyout      = hreadyout_r;
	assign hrdata         = hrdata_r;
	assign hresp          = 1'b0;
	assign div_to_phase   = div_phase_r;
	assign div_to_ifc     = div_ifc_r;
	assign doubler_clk    = doubler_r;
	assign osc_gain       = osc_gain_r;
	assign intfreq_gain   = if_gain_r;
	assign pll_on         = pll_on_r;
	assign core_supply_en = supply_r;

	assign acc_ok  = hsel && htrans[1] && hready;
	assign wr_hi   = wr_pend_r && (addr_r == pdiv_pkg::OFS_DIV_HI);
	assign wr_ref  = wr_pend_r && (addr_r == pdiv_pkg::OFS_REFSEL);
	assign run_now = (refsel_r != pdiv_pkg::PLL_OFF); // [RL15]

	assign cif.run          = run_now; // [RL1]
	assign cif.osc_edge     = local_osc_input && !osc_d_r;
	assign cif.swallow_mode = mode_r[pdiv_pkg::MODE_SWL_B]; // [RL4]
	assign cif.divisor      = active_div_r;

	// Register map, one word each with the data in the low bits and the rest read as zero.
	// The mode word at 00h holds the swallow select in bit 0; bit 3 is stored but unused.
	// The low divisor word at 04h stages divisor bits 11 to 0.
	// The high divisor word at 08h stages bits 15 to 12 and commits all sixteen at once.
	// The gain word at 0ch holds the oscillator gain in bits 1:0 and the IF gain in bits 3:2.
	// The reference select word at 10h stops the divider while it holds all ones.
	// The status word at 14h shows the active divisor, run state in bit 16, mode in bit 17.
	// Other offsets ignore writes and read as zero, still with an OKAY answer.
	// Reads take one wait state so a write just before them is seen, except by the status run bit, which lags one cycle.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			addr_r      <= 8'h00;
			hreadyout_r <= 1'b1;
		end else begin
			wr_pend_r   <= acc_ok && hwrite;
			rd_pend_r   <= acc_ok && !hwrite;
			hreadyout_r <= !(acc_ok && !hwrite);
			if (acc_ok) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (addr_r) // [RL8]
			pdiv_pkg::OFS_MODE:   rd_mux[3:0]  = mode_r;
			pdiv_pkg::OFS_DIV_LO: rd_mux[11:0] = stage_lo_r;
			pdiv_pkg::OFS_DIV_HI: rd_mux[3:0]  = stage_hi_r;
			pdiv_pkg::OFS_GAIN:   rd_mux[3:0]  = gain_r;
			pdiv_pkg::OFS_REFSEL: rd_mux[3:0]  = refsel_r;
			pdiv_pkg::OFS_STATUS: begin
				rd_mux[15:0]                  = active_div_r;
				rd_mux[pdiv_pkg::STAT_ON_B]  = pll_on_r;
				rd_mux[pdiv_pkg::STAT_SWL_B] = mode_r[pdiv_pkg::MODE_SWL_B];
			end
			default:              rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hrdata_r <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_mux;
		end
	end

	// All setting registers sit on the always-on clock, so a dropped core supply loses nothing.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= pdiv_pkg::MODE_RST; // [RL17]
		end else if (wr_pend_r && addr_r == pdiv_pkg::OFS_MODE) begin // [RL8] [RL13]
			mode_r <= hwdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage_lo_r <= pdiv_pkg::DIV_RST[11:0];
			stage_hi_r <= pdiv_pkg::DIV_RST[15:12];
		end else begin
			if (wr_pend_r && addr_r == pdiv_pkg::OFS_DIV_LO) begin
				stage_lo_r <= hwdata[11:0];
			end
			if (wr_hi) begin
				stage_hi_r <= hwdata[3:0];
			end
		end
	end

	// Only the top nibble or the reference select moves the staged value, so a half-written
	// divisor reaches the counters if the top nibble is written first or the reference select is written between the halves.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			active_div_r <= pdiv_pkg::DIV_RST; // [RL17]
		end else if (wr_hi) begin
			active_div_r <= {hwdata[3:0], stage_lo_r}; // [RL6] [RL7]
		end else if (wr_ref) begin
			active_div_r <= {stage_hi_r, stage_lo_r}; // [RL14]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			gain_r <= pdiv_pkg::GAIN_RST; // [RL10]
		end else if (wr_pend_r && addr_r == pdiv_pkg::OFS_GAIN) begin
			gain_r <= hwdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			refsel_r <= pdiv_pkg::REFSEL_RST; // [RL15]
		end else if (wr_ref) begin
			refsel_r <= hwdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_d_r   <= 1'b0;
			doubler_r <= 1'b0;
		end else begin
			osc_d_r   <= local_osc_input;
			doubler_r <= local_osc_input; // [RL12]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_phase_r <= 1'b0;
			div_ifc_r   <= 1'b0;
		end else begin
			div_phase_r <= cif.fire; // [RL12]
			div_ifc_r   <= cif.fire; // [RL12]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_gain_r <= pdiv_pkg::GAIN_RST[1:0];
			if_gain_r  <= pdiv_pkg::GAIN_RST[3:2];
		end else begin
			osc_gain_r <= gain_r[1:0]; // [RL9]
			if_gain_r  <= gain_r[3:2]; // [RL9]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pll_on_r <= 1'b0;
			supply_r <= 1'b0;
		end else begin
			pll_on_r <= run_now; // [RL15]
			supply_r <= run_now; // [RL13]
		end
	end

	a_halt_when_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL1] [RL15]
		(refsel_r == pdiv_pkg::PLL_OFF) [*2] |=> !div_phase_r && !div_ifc_r)
		else $error("divided pulse seen while the PLL is off");

	a_msb_commit: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
		wr_hi |=> active_div_r == {$past(hwdata[3:0]), $past(stage_lo_r)})
		else $error("top nibble write did not commit all divisor bits");

	a_div_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6] [RL13]
		!wr_hi && !wr_ref |=> $stable(active_div_r))
		else $error("active divisor changed without a commit");

	a_refsel_xfer: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL14]
		wr_ref && !wr_hi |=> active_div_r == $past({stage_hi_r, stage_lo_r}))
		else $error("reference select write did not transfer the staged divisor");

	a_gain_reset: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL10]
		$rose(rst_b) |-> gain_r == pdiv_pkg::GAIN_RST && {if_gain_r, osc_gain_r} == 4'hf)
		else $error("gain bits not all ones after reset");

	a_gain_pins: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL9]
		##1 {if_gain_r, osc_gain_r} == $past(gain_r))
		else $error("gain pins do not follow the gain register");

	a_div_reset: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL17]
		$rose(rst_b) |-> active_div_r == 16'h0000 && mode_r == 4'h0 && !pll_on_r)
		else $error("divisor or mode not cleared by reset");

	a_fire_pair: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
		cif.fire |=> div_phase_r && div_ifc_r ##1 !div_phase_r)
		else $error("divided pulse not delivered to both consumers");

	a_doubler_raw: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
		##1 doubler_r == $past(local_osc_input))
		else $error("doubler clock does not follow the oscillator input");

	a_read_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc_ok && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
		else $error("read answer not given after one wait state");

	// Register bus checks look one edge after the access is taken; setting and read checks one edge after its data phase.
	a_write_nowait: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
		acc_ok && hwrite |=> hreadyout_r)
		else $error("write answered with a wait state");

	a_rd_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
		!rd_pend_r |=> $stable(hrdata_r))
		else $error("read data changed outside a read");

	a_read_mode: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
		rd_pend_r && addr_r == pdiv_pkg::OFS_MODE |=> hrdata_r == {28'h0, $past(mode_r)})
		else $error("mode read returned the wrong value");

	a_read_refsel: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL15]
		rd_pend_r && addr_r == pdiv_pkg::OFS_REFSEL |=> hrdata_r == {28'h0, $past(refsel_r)})
		else $error("reference select read returned the wrong value");

	a_read_status: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL13]
		rd_pend_r && addr_r == pdiv_pkg::OFS_STATUS |=> hrdata_r[15:0] == $past(active_div_r))
		else $error("status read did not show the active divisor");

	a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
		rd_pend_r && addr_r > pdiv_pkg::OFS_STATUS |=> hrdata_r == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	a_mode_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL4] [RL8]
		wr_pend_r && addr_r == pdiv_pkg::OFS_MODE |=> mode_r == $past(hwdata[3:0]))
		else $error("mode write did not land");

	a_gain_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL9]
		wr_pend_r && addr_r == pdiv_pkg::OFS_GAIN |=> gain_r == $past(hwdata[3:0]))
		else $error("gain write did not land");

	a_refsel_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL15]
		wr_ref |=> refsel_r == $past(hwdata[3:0]))
		else $error("reference select write did not land");

	a_stage_lo_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
		wr_pend_r && addr_r == pdiv_pkg::OFS_DIV_LO |=> stage_lo_r == $past(hwdata[11:0]))
		else $error("low divisor write did not reach the staging register");

	a_stage_hi_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
		wr_hi |=> stage_hi_r == $past(hwdata[3:0]))
		else $error("high divisor write did not reach the staging register");

	a_pll_on_state: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL15]
		##1 pll_on_r == ($past(refsel_r) != pdiv_pkg::PLL_OFF))
		else $error("run flag does not follow the reference select");

	a_off_no_fire: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL1]
		!run_now |=> !cif.fire)
		else $error("divider fired while stopped");

	a_keep_unpowered: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL13]
		!supply_r && !wr_pend_r |=> $stable(mode_r) && $stable(active_div_r))
		else $error("settings changed while the core supply was off");

	a_pulse_single: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
		div_phase_r |=> !div_phase_r)
		else $error("divided pulse stood longer than one cycle");

	c_msb_commit: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_hi);
	c_pll_start: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(pll_on_r));
	c_status_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
		rd_pend_r && addr_r == pdiv_pkg::OFS_STATUS);
endmodule

// >>> src/pdiv_pkg.sv
package pdiv_pkg;
	localparam logic [7:0]  OFS_MODE    = 8'h00;
	localparam logic [7:0]  OFS_DIV_LO  = 8'h04;
	localparam logic [7:0]  OFS_DIV_HI  = 8'h08;
	localparam logic [7:0]  OFS_GAIN    = 8'h0c;
	localparam logic [7:0]  OFS_REFSEL  = 8'h10;
	localparam logic [7:0]  OFS_STATUS  = 8'h14;
	localparam logic [3:0]  MODE_RST    = 4'h0;
	localparam logic [3:0]  GAIN_RST    = 4'hf;
	localparam logic [3:0]  REFSEL_RST  = 4'hf;
	localparam logic [3:0]  PLL_OFF     = 4'hf;
	localparam logic [15:0] DIV_RST     = 16'h0000;
	localparam int          MODE_SWL_B  = 0;
	localparam int          STAT_ON_B   = 16;
	localparam int          STAT_SWL_B  = 17;
	localparam int          DIV_LO_W    = 12;
	localparam logic [3:0]  PRE_TERM_16 = 4'hf;
	localparam logic [3:0]  PRE_TERM_15 = 4'he;
endpackage

// >>> src/pdiv_core_if.sv
interface pdiv_core_if;
	logic        run;
	logic        osc_edge;
	logic        swallow_mode;
	logic [15:0] divisor;
	logic        fire;
	modport ctl (output run, output osc_edge, output swallow_mode, output divisor, input fire);
	modport core (input run, input osc_edge, input swallow_mode, input divisor, output fire);
endinterface

// >>> src/pdiv_core.sv
module pdiv_core #(
	parameter int MAIN_W = 12, // Divisor field width; the binary counter is one bit wider.
	parameter int SWAL_W = 4   // Swallow counter width.
) (
	input  wire logic    clk_sys, // System clock.
	input  wire logic    rst_b,   // Asynchronous reset, active low.
	pdiv_core_if.core    cif      // Control and divided output.
);
	logic [3:0]        pre_r;
	logic [SWAL_W-1:0] swal_r;
	logic [MAIN_W:0]   main_r;
	logic              fire_r;
	logic [MAIN_W-1:0] msb_part;
	logic [SWAL_W-1:0] low_part;
	logic [MAIN_W:0]   load_main;
	logic [SWAL_W-1:0] load_swal;
	logic [3:0]        pre_term;
	logic              pre_wrap;
	logic              main_done;
	logic              done_now;

	assign msb_part  = cif.divisor[MAIN_W+SWAL_W-1:SWAL_W];
	assign low_part  = cif.divisor[SWAL_W-1:0];
	assign pre_term  = (swal_r != '0) ? pdiv_pkg::PRE_TERM_15 : pdiv_pkg::PRE_TERM_16;
	assign pre_wrap  = !cif.swallow_mode || (pre_r == pre_term);
	assign main_done = (main_r <= (MAIN_W+1)'(1));
	assign done_now  = cif.run && cif.osc_edge && pre_wrap && main_done;
	assign cif.fire  = fire_r;

	// A swallow of 16-A periods at /15 with one extra /16 period gives exactly 16*M+A.
	always_comb begin
		load_main = {1'b0, msb_part};
		load_swal = '0;
		if (cif.swallow_mode && low_part != '0) begin // [RL16]
			load_main = {1'b0, msb_part} + (MAIN_W+1)'(1);
			load_swal = '0 - low_part;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_r <= 4'h0;
		end else if (!cif.run) begin // [RL1]
			pre_r <= 4'h0;
		end else if (cif.osc_edge && cif.swallow_mode) begin // [RL3]
			pre_r <= pre_wrap ? 4'h0 : pre_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			swal_r <= '0;
		end else if (!cif.run) begin
			swal_r <= load_swal;
		end else if (cif.osc_edge && pre_wrap && cif.swallow_mode) begin // [RL3]
			if (main_done) begin
				swal_r <= load_swal;
			end else if (swal_r != '0) begin
				swal_r <= swal_r - SWAL_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			main_r <= '0;
		end else if (!cif.run) begin
			main_r <= load_main;
		end else if (cif.osc_edge && pre_wrap) begin // [RL2]
			main_r <= main_done ? load_main : main_r - (MAIN_W+1)'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fire_r <= 1'b0;
		end else begin
			fire_r <= done_now; // [RL17]
		end
	end

	// Helper logic that only the ratio check and the two period covers read.
	logic [16:0] since_r;
	logic [16:0] cfg_snap_r;
	logic        clean_r;
	logic [16:0] cfg_now;
	assign cfg_now = {cif.swallow_mode, cif.divisor};

	function automatic logic [16:0] exp_of(input logic [16:0] cfg);
		exp_of = cfg[16] ? {1'b0, cfg[15:0]} : {5'h00, cfg[15:4]};
	endfunction

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			since_r    <= 17'h00000;
			cfg_snap_r <= 17'h00000;
			clean_r    <= 1'b0;
		end else if (!cif.run) begin
			since_r <= 17'h00000;
			clean_r <= 1'b0;
		end else if (done_now) begin
			since_r    <= 17'h00000;
			cfg_snap_r <= cfg_now;
			clean_r    <= 1'b1;
		end else begin
			since_r <= cif.osc_edge ? since_r + 17'h00001 : since_r;
			clean_r <= clean_r && (cfg_now == cfg_snap_r);
		end
	end

	a_ratio_exact: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL16] [RL2] [RL3]
		done_now && clean_r |-> (since_r + 17'h00001) == exp_of(cfg_snap_r))
		else $error("divided period does not match the programmed divisor");

	c_swallow_period: cover property (@(posedge clk_sys) disable iff (!rst_b)
		done_now && clean_r && cfg_snap_r[16]);
	c_direct_period: cover property (@(posedge clk_sys) disable iff (!rst_b)
		done_now && clean_r && !cfg_snap_r[16]);
endmodule

// >>> testbench/pdiv_osc_model.sv
module pdiv_osc_model (
	input  wire logic clk_sys, // System clock.
	input  wire logic rst_b,   // Asynchronous reset, active low.
	input  wire logic slow,    // Uneven slow waveform when high.
	output logic      osc      // Oscillator output, synchronous to clk_sys.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_r;
	// Slow mode is one clock high and three low, the shortest high phase the divider accepts.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ph_r <= 2'h0;
			osc  <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'h1;
			osc  <= slow ? (ph_r == 2'h3) : ~osc;
		end
	end
endmodule

// >>> testbench/test_pll_programmable_divider.sv
module test_pll_programmable_divider;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst_b, hsel, hwrite, slow, hreadyout, hresp, osc;
	logic        div_to_phase, div_to_ifc, doubler_clk, pll_on, core_supply_en, osc_q, rst_q;
	logic [1:0]  htrans, osc_gain, intfreq_gain;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, per_r;
	logic [15:0] d;
	logic [3:0]  gl [4];
	logic        swl;
	int          n_errors, cmp_count, n_pulse, edge_tot, mark, n;

	pdiv_top u_pdiv_top (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .local_osc_input(osc),
		.div_to_phase(div_to_phase), .div_to_ifc(div_to_ifc), .doubler_clk(doubler_clk),
		.osc_gain(osc_gain), .intfreq_gain(intfreq_gain), .pll_on(pll_on),
		.core_supply_en(core_supply_en));
	pdiv_osc_model u_pdiv_osc_model (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .osc(osc));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic clks(input int c);
		repeat (c) @(posedge clk_sys);
	endtask

	// Entered just after a rising edge; holds each phase until hready is sampled high.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		ahb(1'b1, a, v);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic wait_pulses(input int k);
		int tgt;
		int t;
		tgt = n_pulse + k;
		t = 0;
		while (n_pulse < tgt && t < 30000) begin
			@(posedge clk_sys);
			t++;
		end
		chk(n_pulse, tgt);
	endtask

	function automatic logic [31:0] exp_per(input logic s, input logic [15:0] v);
		return s ? {16'h0, v} : {20'h0, v[15:4]};
	endfunction

	task automatic run_div(input logic s, input logic [15:0] v, input logic sl,
		input logic [3:0] rc);
		slow <= sl;
		wr(pdiv_pkg::OFS_REFSEL, 32'hf);
		wr(pdiv_pkg::OFS_DIV_LO, {20'h0, v[11:0]});
		wr(pdiv_pkg::OFS_DIV_HI, {28'h0, v[15:12]});
		wr(pdiv_pkg::OFS_MODE, {31'h0, s});
		wr(pdiv_pkg::OFS_REFSEL, {28'h0, rc});
		clks(2);
		chk(pll_on, 1'b1);
		chk(core_supply_en, 1'b1);
		rchk(pdiv_pkg::OFS_STATUS, {14'h0, s, 1'b1, v});
		wait_pulses(3);
		chk(per_r, exp_per(s, v));
		swl = s;
		d = v;
	endtask

	// Edges are counted as the divider sees them; the pulse lag is constant, so it cancels.
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			osc_q <= osc;
			rst_q <= 1'b1;
			if (osc === 1'b1 && osc_q === 1'b0)
				edge_tot <= edge_tot + 1;
			if (div_to_phase !== 1'b0) begin
				per_r   <= edge_tot - mark;
				mark    <= edge_tot;
				n_pulse <= n_pulse + 1;
			end
			if (div_to_phase !== 1'b0 || div_to_ifc !== 1'b0)
				chk(div_to_ifc, div_to_phase);
			if (rst_q)
				chk(doubler_clk, osc_q);
		end
	end

	task automatic give_verdict();
		$display("n_errors=%0d cmp_count=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		clks(90000);
		n_errors++;
		give_verdict();
	end

	initial begin
		rst_b = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		slow = 1'b0;
		void'($urandom(32'hb7663af6));
		clks(8);
		rst_b <= 1'b1;
		clks(2);
		chk(osc_gain, 2'h3);
		chk(intfreq_gain, 2'h3);
		chk(pll_on, 1'b0);
		chk(hresp, 1'b0);
		rchk(pdiv_pkg::OFS_MODE, 32'h0);
		rchk(pdiv_pkg::OFS_GAIN, 32'hf);
		rchk(pdiv_pkg::OFS_REFSEL, 32'hf);
		rchk(pdiv_pkg::OFS_STATUS, 32'h0);
		clks(200);
		chk(n_pulse, 0);
		wr(8'h18, 32'hffffffff);
		rchk(8'h18, 32'h0);
		gl = '{4'h0, 4'h5, 4'($urandom), 4'hf};
		foreach (gl[i]) begin
			wr(pdiv_pkg::OFS_GAIN, {28'h0, gl[i]});
			clks(2);
			chk(osc_gain, gl[i][1:0]);
			chk(intfreq_gain, gl[i][3:2]);
			rchk(pdiv_pkg::OFS_GAIN, {28'h0, gl[i]});
		end
		wr(pdiv_pkg::OFS_DIV_LO, 32'h345);
		rchk(pdiv_pkg::OFS_STATUS, 32'h0);
		wr(pdiv_pkg::OFS_DIV_HI, 32'h1);
		rchk(pdiv_pkg::OFS_STATUS, 32'h1345);
		wr(pdiv_pkg::OFS_DIV_LO, 32'h678);
		wr(pdiv_pkg::OFS_REFSEL, 32'hf);
		rchk(pdiv_pkg::OFS_STATUS, 32'h1678);
		run_div(1'b0, 16'h0100, 1'b0, 4'h0);
		run_div(1'b0, 16'hfff0, 1'b0, 4'h9);
		run_div(1'b1, 16'h0210, 1'b1, 4'h3);
		for (int i = 0; i < 4; i++) begin
			if (i[0])
				run_div(1'b1, 16'h210 + 16'($urandom % 32'h1f0), 1'($urandom),
					4'($urandom % 10));
			else
				run_div(1'b0, {12'h010 + 12'($urandom % 32'h1f0), 4'($urandom)},
					1'($urandom), 4'($urandom % 10));
		end
		for (int r = 0; r < 10; r++) begin
			wr(pdiv_pkg::OFS_REFSEL, 32'(r));
			clks(2);
			chk(pll_on, 1'b1);
		end
		wr(pdiv_pkg::OFS_REFSEL, 32'hf);
		clks(4);
		n = n_pulse;
		clks(4200);
		chk(n_pulse, n);
		chk(pll_on, 1'b0);
		chk(core_supply_en, 1'b0);
		rchk(pdiv_pkg::OFS_STATUS, {14'h0, swl, 1'b0, d});
		wr(pdiv_pkg::OFS_GAIN, 32'h0);
		rst_b <= 1'b0;
		clks(2);
		chk(osc_gain, 2'h3);
		chk(intfreq_gain, 2'h3);
		chk(div_to_phase, 1'b0);
		rst_b <= 1'b1;
		clks(2);
		rchk(pdiv_pkg::OFS_STATUS, 32'h0);
		rchk(pdiv_pkg::OFS_MODE, 32'h0);
		give_verdict();
	end
endmodule
